//--- hw/rcw_regs.sv
// Radio configuration and wake timer register bank
//
// How it works
// - 7-bit discriminator bandwidth code, reset 6, held in its register.
// - Shaping bit 1 selects Gaussian, bit 0 pre-emphasis, resets to 1.
// - Shaping bits 7:2 belong to radio controller, host writes ignored.
// - Received power readback, signed, read only, reset zero.
// - Signal quality readback, read only, reset zero.
// - Data rate is 100 bps times upper:lower bytes, reset 78 and 32.
// - Transmit buffer base pointer, read/write, reset 128.
// - Receive buffer base pointer, read/write, reset 0.
// - Prescaler codes 0..7 divide slow clock by 1 up to 65536.
// - Prescaler write-only staging, applied on sleep setup write.
// - Sleep retention field codes 1, 4, 5, 11; others reserved.
// - Sleep setup bit 0 enables wake on timer expiry, reset 0.
// - 16-bit reload split high/low bytes, both reset zero.
// - High reload byte staged, whole value applied on low byte write.
// - Crystal settled status valid only for retention codes 4 or 5.
// - Expiry sets a sticky flag until software flag reset pulse.
`timescale 1ns/1ns
`default_nettype none
module rcw_regs #(
   parameter int ADDR_W = rcw_pkg::ADDR_W
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] i_ctrl_tx_bits,
   input wire logic i_ctrl_tx_bits_we,
   input wire logic [7:0] i_rx_power,
   input wire logic [7:0] i_sig_quality,
   input wire logic i_meas_valid,
   input wire logic i_slow_tick,
   input wire logic i_xtal_running,
   input wire logic i_flag_reset,
   output logic [7:0] o_rdata,
   output logic o_rdata_valid,
   output logic [6:0] o_discrim_bandwidth_code,
   output logic o_gauss_shaping,
   output logic o_preemph_en,
   output logic [5:0] o_controller_owned_bits,
   output logic [15:0] o_data_rate,
   output logic [3:0] o_pram_page,
   output logic [7:0] o_tx_base,
   output logic [7:0] o_rx_base,
   output logic [3:0] o_sleep_mode,
   output logic o_sleep_mode_valid,
   output logic o_wake_en,
   output logic o_slow_crystal_settled,
   output logic o_expiry_flag,
   output logic o_wake_request
);
   rcw_timer_if tif ();

   logic [7:0] discrim_reg;
   logic [7:0] tx_shape_reg;
   logic [7:0] rx_power_reg;
   logic [7:0] sig_qual_reg;
   logic [7:0] rate_hi_reg;
   logic [7:0] rate_lo_reg;
   logic [7:0] pram_reg;
   logic [7:0] tx_base_reg;
   logic [7:0] rx_base_reg;
   logic [2:0] pre_stage_reg;
   logic [2:0] pre_active_reg;
   logic [7:0] sleep_reg;
   logic sleep_valid_reg;
   logic [7:0] rld_hi_stage_reg;
   logic [15:0] reload_reg;
   logic commit_reg;
   logic expiry_reg;
   logic settled_reg;
   logic wake_req_reg;
   logic [7:0] rdata_reg;
   logic rvalid_reg;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [9:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction : hit

   function automatic logic sleep_ok(input logic [3:0] c);
      sleep_ok = (c == rcw_pkg::SLEEP_KEEP_RAM)
         || (c == rcw_pkg::SLEEP_KEEP_XTAL)
         || (c == rcw_pkg::SLEEP_KEEP_RAM_XTAL)
         || (c == rcw_pkg::SLEEP_KEEP_RAM_RC);
   endfunction : sleep_ok

   wire w_discrim = i_wr_en && hit(i_addr, rcw_pkg::OFS_DISCRIM);
   wire w_tx_shape = i_wr_en && hit(i_addr, rcw_pkg::OFS_TX_SHAPE);
   wire w_rate_hi = i_wr_en && hit(i_addr, rcw_pkg::OFS_RATE_HI);
   wire w_rate_lo = i_wr_en && hit(i_addr, rcw_pkg::OFS_RATE_LO);
   wire w_pram = i_wr_en && hit(i_addr, rcw_pkg::OFS_PRAM_PAGE);
   wire w_tx_base = i_wr_en && hit(i_addr, rcw_pkg::OFS_TX_BASE);
   wire w_rx_base = i_wr_en && hit(i_addr, rcw_pkg::OFS_RX_BASE);
   wire w_prescale = i_wr_en && hit(i_addr, rcw_pkg::OFS_PRESCALE);
   wire w_sleep = i_wr_en && hit(i_addr, rcw_pkg::OFS_SLEEP);
   wire w_rld_hi = i_wr_en && hit(i_addr, rcw_pkg::OFS_RELOAD_HI);
   wire w_rld_lo = i_wr_en && hit(i_addr, rcw_pkg::OFS_RELOAD_LO);

   wire [3:0] sleep_field = sleep_reg[rcw_pkg::SLEEP_LSB +: rcw_pkg::SLEEP_W];
   wire [3:0] wr_sleep_field =
      i_wdata[rcw_pkg::SLEEP_LSB +: rcw_pkg::SLEEP_W];
   wire xtal_kept = (sleep_field == rcw_pkg::SLEEP_KEEP_XTAL)
      || (sleep_field == rcw_pkg::SLEEP_KEEP_RAM_XTAL);
   // Host may only touch bits 1:0; controller updates the rest
   wire [7:0] tx_shape_next = w_tx_shape
      ? ((tx_shape_reg & rcw_pkg::MASK_TX_CTRL)
         | (i_wdata & rcw_pkg::MASK_TX_HOST))
      : i_ctrl_tx_bits_we
      ? ((tx_shape_reg & rcw_pkg::MASK_TX_HOST)
         | (i_ctrl_tx_bits & rcw_pkg::MASK_TX_CTRL))
      : tx_shape_reg;
   // Expiry beats flag reset in the same cycle so no event is lost
   wire expiry_next = tif.expired ? 1'b1
      : (i_flag_reset ? 1'b0 : expiry_reg);

   // Read mux; prescaler and high reload byte are write-only, read zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (1'b1)
         hit(i_addr, rcw_pkg::OFS_DISCRIM): rd_mux = discrim_reg;
         hit(i_addr, rcw_pkg::OFS_TX_SHAPE): rd_mux = tx_shape_reg;
         hit(i_addr, rcw_pkg::OFS_RX_POWER): rd_mux = rx_power_reg;
         hit(i_addr, rcw_pkg::OFS_SIG_QUAL): rd_mux = sig_qual_reg;
         hit(i_addr, rcw_pkg::OFS_RATE_HI): rd_mux = rate_hi_reg;
         hit(i_addr, rcw_pkg::OFS_RATE_LO): rd_mux = rate_lo_reg;
         hit(i_addr, rcw_pkg::OFS_PRAM_PAGE): rd_mux = pram_reg;
         hit(i_addr, rcw_pkg::OFS_TX_BASE): rd_mux = tx_base_reg;
         hit(i_addr, rcw_pkg::OFS_RX_BASE): rd_mux = rx_base_reg;
         hit(i_addr, rcw_pkg::OFS_SLEEP): rd_mux = sleep_reg;
         hit(i_addr, rcw_pkg::OFS_RELOAD_LO): rd_mux = reload_reg[7:0];
         default: rd_mux = 8'h00;
      endcase
   end

   // One short block per register or group of related registers keeps each reset value easy to audit
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         discrim_reg <= rcw_pkg::RST_DISCRIM;
      end else if (w_discrim) begin
         discrim_reg <= i_wdata & rcw_pkg::MASK_DISCRIM;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_shape_reg <= rcw_pkg::RST_TX_SHAPE;
      end else begin
         tx_shape_reg <= tx_shape_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rate_hi_reg <= rcw_pkg::RST_RATE_HI;
      end else if (w_rate_hi) begin
         rate_hi_reg <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rate_lo_reg <= rcw_pkg::RST_RATE_LO;
      end else if (w_rate_lo) begin
         rate_lo_reg <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pram_reg <= rcw_pkg::RST_ZERO;
      end else if (w_pram) begin
         pram_reg <= i_wdata & rcw_pkg::MASK_PRAM;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_base_reg <= rcw_pkg::RST_TX_BASE;
      end else if (w_tx_base) begin
         tx_base_reg <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_base_reg <= rcw_pkg::RST_ZERO;
      end else if (w_rx_base) begin
         rx_base_reg <= i_wdata;
      end
   end

   // Readbacks follow the measurement port only; host writes never land
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_power_reg <= rcw_pkg::RST_ZERO;
         sig_qual_reg <= rcw_pkg::RST_ZERO;
      end else if (i_meas_valid) begin
         rx_power_reg <= i_rx_power;
         sig_qual_reg <= i_sig_quality;
      end
   end

   // Staged prescaler; the timer sees it only after a sleep setup write
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pre_stage_reg <= '0;
      end else if (w_prescale) begin
         pre_stage_reg <= i_wdata[2:0];
      end
   end

   // Mode validity registered with the field so the output is a flop
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sleep_reg <= rcw_pkg::RST_ZERO;
         sleep_valid_reg <= 1'b0;
         pre_active_reg <= '0;
      end else if (w_sleep) begin
         sleep_reg <= i_wdata & rcw_pkg::MASK_SLEEP;
         sleep_valid_reg <= sleep_ok(wr_sleep_field);
         pre_active_reg <= pre_stage_reg;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rld_hi_stage_reg <= rcw_pkg::RST_ZERO;
      end else if (w_rld_hi) begin
         rld_hi_stage_reg <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         reload_reg <= '0;
      end else if (w_rld_lo) begin
         reload_reg <= {rld_hi_stage_reg, i_wdata};
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         commit_reg <= 1'b0;
      end else begin
         commit_reg <= w_sleep || w_rld_lo;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         expiry_reg <= 1'b0;
      end else begin
         expiry_reg <= expiry_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         settled_reg <= 1'b0;
      end else begin
         settled_reg <= xtal_kept && i_xtal_running;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wake_req_reg <= 1'b0;
      end else begin
         wake_req_reg <= tif.expired && sleep_reg[rcw_pkg::BIT_WAKE_EN];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_reg <= rcw_pkg::RST_ZERO;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= i_rd_en ? rd_mux : rdata_reg;
         rvalid_reg <= i_rd_en;
      end
   end

   assign tif.prescale = pre_active_reg;
   assign tif.reload = reload_reg;
   assign tif.wake_en = sleep_reg[rcw_pkg::BIT_WAKE_EN];
   assign tif.commit = commit_reg;
   assign tif.slow_tick = i_slow_tick;

   rcw_wake_timer u_timer (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .tif(tif.timer)
   );

   assign o_rdata = rdata_reg;
   assign o_rdata_valid = rvalid_reg;
   assign o_discrim_bandwidth_code = discrim_reg[6:0];
   assign o_gauss_shaping = tx_shape_reg[rcw_pkg::BIT_GAUSS];
   assign o_preemph_en = tx_shape_reg[rcw_pkg::BIT_PREEMPH];
   assign o_controller_owned_bits = tx_shape_reg[7:2];
   assign o_data_rate = {rate_hi_reg, rate_lo_reg};
   assign o_pram_page = pram_reg[3:0];
   assign o_tx_base = tx_base_reg;
   assign o_rx_base = rx_base_reg;
   assign o_sleep_mode = sleep_field;
   assign o_sleep_mode_valid = sleep_valid_reg;
   assign o_wake_en = sleep_reg[rcw_pkg::BIT_WAKE_EN];
   assign o_slow_crystal_settled = settled_reg;
   assign o_expiry_flag = expiry_reg;
   assign o_wake_request = wake_req_reg;
endmodule : rcw_regs
`default_nettype wire

//--- hw/rcw_pkg.sv
// Package: register offsets, reset values and field layout of the bank
package rcw_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam logic [9:0] OFS_DISCRIM = 10'h305;
   localparam logic [9:0] OFS_TX_SHAPE = 10'h306;
   localparam logic [9:0] OFS_RX_POWER = 10'h30C;
   localparam logic [9:0] OFS_SIG_QUAL = 10'h30D;
   localparam logic [9:0] OFS_RATE_HI = 10'h30E;
   localparam logic [9:0] OFS_RATE_LO = 10'h30F;
   localparam logic [9:0] OFS_PRAM_PAGE = 10'h313;
   localparam logic [9:0] OFS_TX_BASE = 10'h314;
   localparam logic [9:0] OFS_RX_BASE = 10'h315;
   localparam logic [9:0] OFS_PRESCALE = 10'h316;
   localparam logic [9:0] OFS_SLEEP = 10'h317;
   localparam logic [9:0] OFS_RELOAD_HI = 10'h318;
   localparam logic [9:0] OFS_RELOAD_LO = 10'h319;
   localparam logic [7:0] RST_DISCRIM = 8'h06;
   localparam logic [7:0] RST_TX_SHAPE = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_RATE_HI = 8'h4E;
   localparam logic [7:0] RST_RATE_LO = 8'h20;
   localparam logic [7:0] RST_TX_BASE = 8'h80;
   localparam logic [7:0] MASK_DISCRIM = 8'h7F;
   localparam logic [7:0] MASK_TX_HOST = 8'h03;
   localparam logic [7:0] MASK_TX_CTRL = 8'hFC;
   localparam logic [7:0] MASK_PRAM = 8'h0F;
   localparam logic [7:0] MASK_PRESCALE = 8'h07;
   localparam logic [7:0] MASK_SLEEP = 8'h79;
   localparam int BIT_GAUSS = 1;
   localparam int BIT_PREEMPH = 0;
   localparam int BIT_WAKE_EN = 0;
   localparam int SLEEP_LSB = 3;
   localparam int SLEEP_W = 4;
   localparam logic [3:0] SLEEP_KEEP_RAM = 4'h1;
   localparam logic [3:0] SLEEP_KEEP_XTAL = 4'h4;
   localparam logic [3:0] SLEEP_KEEP_RAM_XTAL = 4'h5;
   localparam logic [3:0] SLEEP_KEEP_RAM_RC = 4'hB;
   // Divider as shift amount: 1,4,8,16,128,1024,8192,65536
   localparam logic [4:0] DIV_SHIFT [8] = '{5'h00, 5'h02, 5'h03, 5'h04,
                                            5'h07, 5'h0A, 5'h0D, 5'h10};
endpackage : rcw_pkg

//--- hw/rcw_timer_if.sv
// Interface: committed wake timer settings and timer status
`timescale 1ns/1ns
`default_nettype none
interface rcw_timer_if;
   logic [2:0] prescale;
   logic [15:0] reload;
   logic wake_en;
   logic commit;
   logic slow_tick;
   logic expired;
   modport ctrl (output prescale, reload, wake_en, commit, slow_tick,
      input expired);
   modport timer (input prescale, reload, wake_en, commit, slow_tick,
      output expired);
endinterface : rcw_timer_if
`default_nettype wire

//--- hw/rcw_wake_timer.sv
// Wake timer: prescaler on slow clock ticks, reload countdown, expiry pulse
`timescale 1ns/1ns
`default_nettype none
module rcw_wake_timer (
   input wire logic i_clk,
   input wire logic i_rst,
   rcw_timer_if.timer tif
);
   logic [16:0] pre_cnt_reg;
   logic [16:0] pre_limit;
   logic [15:0] count_reg;
   logic pre_done;
   logic expired_reg;

   assign pre_limit =
      (17'h00001 << rcw_pkg::DIV_SHIFT[tif.prescale]) - 17'h00001;
   assign pre_done = tif.slow_tick && (pre_cnt_reg >= pre_limit);
   assign tif.expired = expired_reg;

   // Uses only the committed values, so staged writes never disturb it
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pre_cnt_reg <= '0;
         count_reg <= '0;
         expired_reg <= 1'b0;
      end else if (tif.commit) begin
         pre_cnt_reg <= '0;
         count_reg <= tif.reload;
         expired_reg <= 1'b0;
      end else begin
         expired_reg <= 1'b0;
         if (tif.slow_tick) begin
            pre_cnt_reg <= pre_done ? '0 : pre_cnt_reg + 17'h00001;
         end
         if (pre_done) begin
            if (count_reg == 16'h0000) begin
               count_reg <= tif.reload;
               expired_reg <= 1'b1;
            end else begin
               count_reg <= count_reg - 16'h0001;
            end
         end
      end
   end
endmodule : rcw_wake_timer
`default_nettype wire

//--- test/rcw_regs_properties.sv
// Checker: port-level timing relations of the register bank
`timescale 1ns/1ns
`default_nettype none
module rcw_regs_properties #(
   parameter int ADDR_W = rcw_pkg::ADDR_W
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_ctrl_tx_bits_we,
   input wire logic i_xtal_running,
   input wire logic i_flag_reset,
   input wire logic o_rdata_valid,
   input wire logic [6:0] o_discrim_bandwidth_code,
   input wire logic o_gauss_shaping,
   input wire logic o_preemph_en,
   input wire logic [5:0] o_controller_owned_bits,
   input wire logic [15:0] o_data_rate,
   input wire logic [7:0] o_tx_base,
   input wire logic [7:0] o_rx_base,
   input wire logic [3:0] o_sleep_mode,
   input wire logic o_sleep_mode_valid,
   input wire logic o_wake_en,
   input wire logic o_slow_crystal_settled,
   input wire logic o_expiry_flag,
   input wire logic o_wake_request
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_wr(logic [9:0] a);
      i_wr_en && i_addr == a;
   endsequence
   a_read_answer: assert property (i_rd_en |=> o_rdata_valid)
      else $error("read not answered");
   a_no_spurious: assert property (!i_rd_en |=> !o_rdata_valid)
      else $error("unrequested read valid");
   a_discrim_write: assert property (s_wr(rcw_pkg::OFS_DISCRIM) |=>
      o_discrim_bandwidth_code == $past(i_wdata[6:0]))
      else $error("discriminator code not written");
   a_shape_write: assert property (s_wr(rcw_pkg::OFS_TX_SHAPE) |=>
      {o_gauss_shaping, o_preemph_en} == $past(i_wdata[1:0]))
      else $error("shaping bits not written");
   a_ctrl_bits_kept: assert property (s_wr(rcw_pkg::OFS_TX_SHAPE) ##0
      !i_ctrl_tx_bits_we |=> $stable(o_controller_owned_bits))
      else $error("host changed controller bits");
   a_rate_upper: assert property (s_wr(rcw_pkg::OFS_RATE_HI) |=>
      o_data_rate[15:8] == $past(i_wdata))
      else $error("upper rate byte not written");
   a_tx_base_wr: assert property (s_wr(rcw_pkg::OFS_TX_BASE) |=>
      o_tx_base == $past(i_wdata))
      else $error("tx base not written");
   a_rx_base_wr: assert property (s_wr(rcw_pkg::OFS_RX_BASE) |=>
      o_rx_base == $past(i_wdata))
      else $error("rx base not written");
   a_mode_decode: assert property (o_sleep_mode_valid ==
      (o_sleep_mode inside {4'h1, 4'h4, 4'h5, 4'hB}))
      else $error("sleep mode decode wrong");
   a_wake_enable: assert property (s_wr(rcw_pkg::OFS_SLEEP) |=>
      o_wake_en == $past(i_wdata[0]))
      else $error("wake enable not written");
   a_crystal_ok: assert property (##1 o_slow_crystal_settled ==
      $past(i_xtal_running && o_sleep_mode inside {4'h4, 4'h5}))
      else $error("crystal settled status wrong");
   a_flag_sticky: assert property (o_expiry_flag && !i_flag_reset
      |=> o_expiry_flag)
      else $error("expiry flag dropped");
   a_wake_pulse: assert property (o_wake_request |=> !o_wake_request)
      else $error("wake request longer than a cycle");
endmodule : rcw_regs_properties
bind rcw_regs rcw_regs_properties #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

//--- test/test_radio_config_wake_timer_regs.sv
// Testbench: register bank reset, access kinds and wake timer commit
`timescale 1ns/1ns
`default_nettype none
module test_radio_config_wake_timer_regs;
   logic i_clk = 0, i_rst = 1, i_wr_en = 0, i_rd_en = 0, we_ctl = 0;
   logic meas = 0, tick = 0, xtal = 1, frst = 0;
   logic [9:0] i_addr = 0;
   logic [7:0] i_wdata = 0, ctl = 0, pwr = 0, sq = 0, rdata;
   logic rvalid, sm_valid, settled, flag, wreq;
   logic [3:0] smode;
   logic [6:0] dbw;
   logic gauss, pre, wen;
   logic [5:0] cob;
   logic [15:0] rate;
   logic [3:0] page;
   logic [7:0] txb, rxb;
   int err_count = 0, checks_done = 0, cyc = 0;
   logic [9:0] ra [13] = '{10'h305, 10'h306, 10'h30C, 10'h30D, 10'h30E,
      10'h30F, 10'h313, 10'h314, 10'h315, 10'h316, 10'h317, 10'h318, 10'h319};
   logic [7:0] rv [13] = '{8'h06, 8'h01, 8'h00, 8'h00, 8'h4E, 8'h20, 8'h00,
      8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [9:0] wa [6] = '{10'h305, 10'h30E, 10'h30F, 10'h313, 10'h314, 10'h315};
   logic [7:0] wm [6] = '{8'h7F, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF};
   logic [7:0] d;
   rcw_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr_en(i_wr_en),
      .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_ctrl_tx_bits(ctl), .i_ctrl_tx_bits_we(we_ctl), .i_rx_power(pwr),
      .i_sig_quality(sq), .i_meas_valid(meas), .i_slow_tick(tick),
      .i_xtal_running(xtal), .i_flag_reset(frst), .o_rdata(rdata),
      .o_rdata_valid(rvalid), .o_discrim_bandwidth_code(dbw),
      .o_gauss_shaping(gauss), .o_preemph_en(pre),
      .o_controller_owned_bits(cob), .o_data_rate(rate),
      .o_pram_page(page), .o_tx_base(txb), .o_rx_base(rxb),
      .o_sleep_mode(smode), .o_sleep_mode_valid(sm_valid), .o_wake_en(wen),
      .o_slow_crystal_settled(settled), .o_expiry_flag(flag),
      .o_wake_request(wreq));
   always #50 i_clk = ~i_clk;
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      @(posedge i_clk) #10;
      {i_wr_en, i_addr, i_wdata} = {1'b1, a, v};
      @(posedge i_clk) #10;
      i_wr_en = 0;
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      @(posedge i_clk) #10;
      {i_rd_en, i_addr} = {1'b1, a};
      @(posedge i_clk) #10;
      i_rd_en = 0;
      check({7'h00, rvalid, rdata}, {8'h01, e});
   endtask : rd
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge i_clk) #10 tick = 1;
         @(posedge i_clk) #10 tick = 0;
      end
   endtask : ticks
   function automatic logic mode_ok(input int c);
      return c == 1 || c == 4 || c == 5 || c == 11;
   endfunction : mode_ok
   function automatic logic [5:0] sleep_exp(input int c, input logic x);
      return {mode_ok(c), x && (c == 4 || c == 5), 4'(c)};
   endfunction : sleep_exp
   function automatic logic [7:0] port_of(input logic [9:0] a);
      case (a)
         10'h305: return {1'b0, dbw};
         10'h30E: return rate[15:8];
         10'h30F: return rate[7:0];
         10'h313: return {4'h0, page};
         10'h314: return txb;
         default: return rxb;
      endcase
   endfunction : port_of
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(32'h0319ccf8));
      repeat (16) @(posedge i_clk);
      #10 i_rst = 0;
      foreach (ra[i]) rd(ra[i], rv[i]);
      rd(10'h300, 8'h00);
      $display("Test reset values done");
      for (int k = 0; k < 4; k++) foreach (wa[i]) begin
         d = 8'($urandom);
         wr(wa[i], d);
         rd(wa[i], d & wm[i]);
         check(port_of(wa[i]), d & wm[i]);
      end
      wr(10'h30E, 8'h09);
      wr(10'h30F, 8'hC4);
      wr(10'h305, 8'h19);
      wr(10'h306, 8'h03);
      check(rate, 16'h09C4);
      check({dbw, pre}, {7'h19, 1'b1});
      $display("Test read/write done");
      wr(10'h306, 8'hFE);
      rd(10'h306, 8'h02);
      @(posedge i_clk) #10 {we_ctl, ctl} = {1'b1, 8'hA7};
      @(posedge i_clk) #10 we_ctl = 0;
      rd(10'h306, 8'hA6);
      check({cob, gauss, pre}, 8'hA6);
      {pwr, sq} = 16'($urandom);
      @(posedge i_clk) #10 meas = 1;
      @(posedge i_clk) #10 meas = 0;
      wr(10'h30C, ~pwr);
      wr(10'h30D, ~sq);
      rd(10'h30C, pwr);
      rd(10'h30D, sq);
      $display("Test shaping and readback done");
      for (int c = 0; c < 16; c++) begin
         xtal = 1'($urandom);
         wr(10'h317, 8'(c << 3));
         @(posedge i_clk) #10;
         check({sm_valid, settled, smode}, sleep_exp(c, xtal));
      end
      $display("Test sleep modes done");
      wr(10'h316, 8'h07);
      wr(10'h318, 8'h00);
      wr(10'h319, 8'h03);
      wr(10'h318, 8'hFF);
      rd(10'h316, 8'h00);
      rd(10'h318, 8'h00);
      ticks(12);
      check(flag, 1'b1);
      @(posedge i_clk) #10 frst = 1;
      @(posedge i_clk) #10 frst = 0;
      check(flag, 1'b0);
      wr(10'h317, 8'h21);
      ticks(12);
      check(flag, 1'b0);
      wr(10'h316, 8'h00);
      wr(10'h317, 8'h21);
      wr(10'h318, 8'h00);
      wr(10'h319, 8'h02);
      d = 8'h00;
      repeat (40) begin
         @(posedge i_clk) #10 tick = ~tick;
         if (wreq === 1'b1) d = 8'h01;
      end
      check({flag, d[0]}, 2'b11);
      check(wen, 1'b1);
      $display("Test wake timer done");
      report_and_stop();
   end
endmodule : test_radio_config_wake_timer_regs
`default_nettype wire
